// ===== hdl/gpio_def_pkg.sv
// register map, field layout, reset values and carrier types for the three shared ports
// assumes a single 20 MHz core clock; printed offsets are register indexes, byte address = 4 * index
package gpio_def_pkg;
    // =========================================================
    // register indexes
    localparam logic [7:0] idx_bank_select = 8'h0f;
    localparam logic [7:0] idx_mode_config = 8'h01;
    localparam logic [7:0] idx_hb_direction = 8'h12;
    localparam logic [7:0] idx_hb_pins = 8'h13;
    localparam logic [7:0] idx_ctl_direction = 8'h14;
    localparam logic [7:0] idx_ctl_pins = 8'h15;
    localparam logic [7:0] idx_as_direction = 8'h10;
    localparam logic [7:0] idx_as_pins = 8'h11;
    localparam logic [7:0] idx_converter_cfg = 8'h15;
    localparam int addr_lsb = 2;
    localparam int idx_width = 8;
    // =========================================================
    // banks
    localparam logic [3:0] bank_hb_ctl = 4'h1;
    localparam logic [3:0] bank_analog = 4'h5;
    // =========================================================
    // reset values and widths
    localparam logic [7:0] dir_reset = 8'hff;
    localparam logic [3:0] ctl_dir_reset = 4'hf;
    localparam logic [7:0] latch_por = 8'h00;
    localparam logic [3:0] ctl_latch_por = 4'h0;
    localparam logic [3:0] bank_reset = 4'h0;
    localparam logic [3:0] pcfg_reset = 4'h0;
    localparam logic [3:0] pcfg_digital = 4'he;
    localparam int pcfg_lsb = 0;
    localparam int ctl_width = 4;
    localparam int port_width = 8;
    // =========================================================
    // control port bit positions
    localparam int ctl_bit_ale = 0;
    localparam int ctl_bit_oe = 1;
    localparam int ctl_bit_wr = 2;
    localparam int ctl_bit_capture = 3;
    // =========================================================
    // types
    typedef enum logic [1:0] {
        mode_microprocessor = 2'b00,
        mode_extended_mc = 2'b01,
        mode_microcontroller = 2'b10,
        mode_protected_mc = 2'b11
    } proc_mode_t;
    localparam proc_mode_t mode_reset = mode_microcontroller;
    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_data = 1'b1
    } slave_state_t;
    // strobes and upper address/data from the internal system bus controller
    typedef struct packed {
        logic ale;
        logic oe_n;
        logic wr_n;
        logic ad_hi_drive;
        logic [7:0] ad_hi_out;
    } sys_bus_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } port8_drive_t;
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } port4_drive_t;
endpackage

// ===== hdl/shared_gpio_ports.sv
// high-byte, control and analog-shared ports with banked registers on AHB-Lite
// assumes hclk at 20 MHz, pins asynchronous to it, system bus controller on the same clock
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module shared_gpio_ports (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic warm_reset,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire gpio_def_pkg::sys_bus_t sys_bus,
    output logic [7:0] muxed_addr_data_hi_in,
    output logic capture_four_input,
    input wire logic [7:0] hb_pin_in,
    output gpio_def_pkg::port8_drive_t hb_pin,
    input wire logic [3:0] ctl_pin_in,
    output gpio_def_pkg::port4_drive_t ctl_pin,
    input wire logic [7:0] as_pin_in,
    output gpio_def_pkg::port8_drive_t as_pin,
    output logic [7:0] analog_select
);
    // =========================================================
    // registers
    logic [3:0] bank_select;
    gpio_def_pkg::proc_mode_t mode_config;
    logic [7:0] hb_dir;
    logic [7:0] hb_latch;
    logic [3:0] ctl_dir;
    logic [3:0] ctl_latch;
    logic [7:0] as_dir;
    logic [7:0] as_latch;
    logic [3:0] pcfg;
    logic bus_mode;
    logic analog_mode;
    // =========================================================
    // pin synchronisers: three stages, a change counts once stages two and three agree
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic [19:0] sync3;
    logic [19:0] pin_level;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1 <= 20'h0_0000;
            sync2 <= 20'h0_0000;
            sync3 <= 20'h0_0000;
            pin_level <= 20'h0_0000;
        end
        else
        begin
            sync1 <= {as_pin_in, ctl_pin_in, hb_pin_in};
            sync2 <= sync1;
            sync3 <= sync2;
            pin_level <= (sync2 & ~(sync2 ^ sync3)) | (pin_level & (sync2 ^ sync3));
        end
    end
    wire logic [7:0] hb_level = pin_level[7:0];
    wire logic [3:0] ctl_level = pin_level[11:8];
    wire logic [7:0] as_level = pin_level[19:12];
    assign bus_mode = (mode_config == gpio_def_pkg::mode_microprocessor) ||
                      (mode_config == gpio_def_pkg::mode_extended_mc);
    // only the digital setting releases the pins; every other code keeps them analog
    assign analog_mode = (pcfg != gpio_def_pkg::pcfg_digital);
    // =========================================================
    // AHB-Lite slave: one wait state per transfer so reads never race a preceding write
    gpio_def_pkg::slave_state_t state;
    logic [7:0] req_idx;
    logic req_write;
    logic req_take;
    assign req_take = hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= gpio_def_pkg::st_idle;
            req_idx <= 8'h00;
            req_write <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            case (state)
                gpio_def_pkg::st_idle:
                begin
                    if (req_take)
                    begin
                        state <= gpio_def_pkg::st_data;
                        req_idx <= haddr[gpio_def_pkg::addr_lsb +: gpio_def_pkg::idx_width];
                        req_write <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                gpio_def_pkg::st_data:
                begin
                    state <= gpio_def_pkg::st_idle;
                    hreadyout <= 1'b1;
                end
                default:
                begin
                    state <= gpio_def_pkg::st_idle;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end
    // decode: banked registers answer only in their own bank
    wire logic in_bank1 = (bank_select == gpio_def_pkg::bank_hb_ctl);
    wire logic in_bank5 = (bank_select == gpio_def_pkg::bank_analog);
    wire logic wr_now = (state == gpio_def_pkg::st_data) && req_write;
    logic sel_hb_dir;
    logic sel_hb_pins;
    logic sel_ctl_dir;
    logic sel_ctl_pins;
    logic sel_as_dir;
    logic sel_as_pins;
    logic sel_pcfg;
    assign sel_hb_dir = in_bank1 && (req_idx == gpio_def_pkg::idx_hb_direction);
    assign sel_hb_pins = in_bank1 && (req_idx == gpio_def_pkg::idx_hb_pins);
    assign sel_ctl_dir = in_bank1 && (req_idx == gpio_def_pkg::idx_ctl_direction);
    assign sel_ctl_pins = in_bank1 && (req_idx == gpio_def_pkg::idx_ctl_pins);
    assign sel_as_dir = in_bank5 && (req_idx == gpio_def_pkg::idx_as_direction);
    assign sel_as_pins = in_bank5 && (req_idx == gpio_def_pkg::idx_as_pins);
    assign sel_pcfg = in_bank5 && (req_idx == gpio_def_pkg::idx_converter_cfg);
    // =========================================================
    // read data: pin registers return sampled levels, never the latch
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (req_idx == gpio_def_pkg::idx_bank_select)
            next_rdata[3:0] = bank_select;
        else if (req_idx == gpio_def_pkg::idx_mode_config)
            next_rdata[1:0] = mode_config;
        else if (sel_hb_dir)
            next_rdata[7:0] = hb_dir;
        else if (sel_hb_pins)
            next_rdata[7:0] = hb_level;
        else if (sel_ctl_dir)
            next_rdata[3:0] = ctl_dir;
        else if (sel_ctl_pins)
            next_rdata[3:0] = ctl_level;
        else if (sel_as_dir)
            next_rdata[7:0] = as_dir;
        else if (sel_as_pins)
            next_rdata[7:0] = as_level & ~{8{analog_mode}}; // analog pins read low
        else if (sel_pcfg)
            next_rdata[3:0] = pcfg;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if ((state == gpio_def_pkg::st_data) && !req_write)
            hrdata <= next_rdata;
    end
    // =========================================================
    // configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bank_select <= gpio_def_pkg::bank_reset;
            mode_config <= gpio_def_pkg::mode_reset;
            pcfg <= gpio_def_pkg::pcfg_reset;
        end
        else if (warm_reset)
        begin
            bank_select <= gpio_def_pkg::bank_reset;
            pcfg <= gpio_def_pkg::pcfg_reset;
        end
        else if (wr_now)
        begin
            if (req_idx == gpio_def_pkg::idx_bank_select)
                bank_select <= hwdata[3:0];
            if (req_idx == gpio_def_pkg::idx_mode_config)
                mode_config <= gpio_def_pkg::proc_mode_t'(hwdata[1:0]);
            if (sel_pcfg)
                pcfg <= hwdata[gpio_def_pkg::pcfg_lsb +: 4];
        end
    end
    // =========================================================
    // direction registers: ones on every reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hb_dir <= gpio_def_pkg::dir_reset;
            ctl_dir <= gpio_def_pkg::ctl_dir_reset;
            as_dir <= gpio_def_pkg::dir_reset;
        end
        else if (warm_reset)
        begin
            hb_dir <= gpio_def_pkg::dir_reset;
            ctl_dir <= gpio_def_pkg::ctl_dir_reset;
            as_dir <= gpio_def_pkg::dir_reset;
        end
        else if (wr_now)
        begin
            if (sel_hb_dir)
                hb_dir <= hwdata[7:0];
            if (sel_ctl_dir)
                ctl_dir <= hwdata[3:0];
            if (sel_as_dir)
                as_dir <= hwdata[7:0];
        end
    end
    // =========================================================
    // output latches: cleared only by power-on, kept through warm reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hb_latch <= gpio_def_pkg::latch_por;
            ctl_latch <= gpio_def_pkg::ctl_latch_por;
            as_latch <= gpio_def_pkg::latch_por;
        end
        else if (wr_now && !warm_reset)
        begin
            if (sel_hb_pins)
                hb_latch <= hwdata[7:0];
            if (sel_ctl_pins)
                ctl_latch <= hwdata[3:0];
            if (sel_as_pins)
                as_latch <= hwdata[7:0];
        end
    end
    // =========================================================
    // pin drive
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hb_pin <= '{out: 8'h00, oe_n: 8'hff};
            ctl_pin <= '{out: 4'h0, oe_n: 4'hf};
            as_pin <= '{out: 8'h00, oe_n: 8'hff};
            analog_select <= 8'hff;
            muxed_addr_data_hi_in <= 8'h00;
            capture_four_input <= 1'b0;
        end
        else
        begin
            if (bus_mode)
            begin
                hb_pin.out <= sys_bus.ad_hi_out;
                hb_pin.oe_n <= {8{~sys_bus.ad_hi_drive}};
                ctl_pin.out[gpio_def_pkg::ctl_bit_ale] <= sys_bus.ale;
                ctl_pin.out[gpio_def_pkg::ctl_bit_oe] <= sys_bus.oe_n;
                ctl_pin.out[gpio_def_pkg::ctl_bit_wr] <= sys_bus.wr_n;
                ctl_pin.oe_n[2:0] <= 3'b000;
            end
            else
            begin
                hb_pin.out <= hb_latch;
                hb_pin.oe_n <= hb_dir;
                ctl_pin.out[2:0] <= ctl_latch[2:0];
                ctl_pin.oe_n[2:0] <= ctl_dir[2:0];
            end
            // bit 3 stays general I/O in every mode
            ctl_pin.out[gpio_def_pkg::ctl_bit_capture] <= ctl_latch[gpio_def_pkg::ctl_bit_capture];
            ctl_pin.oe_n[gpio_def_pkg::ctl_bit_capture] <= ctl_dir[gpio_def_pkg::ctl_bit_capture];
            capture_four_input <= ctl_level[gpio_def_pkg::ctl_bit_capture];
            as_pin.out <= as_latch;
            as_pin.oe_n <= analog_mode ? 8'hff : as_dir;
            analog_select <= {8{analog_mode}};
            muxed_addr_data_hi_in <= hb_level;
        end
    end
    // =========================================================
    // assertions
    sequence s_read_take(logic [7:0] idx);
        req_take && !hwrite && state == gpio_def_pkg::st_idle &&
            haddr[gpio_def_pkg::addr_lsb +: gpio_def_pkg::idx_width] == idx;
    endsequence
    sequence s_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    a_dir_input_release: assert property (@(posedge hclk) disable iff (!hresetn)
        (!bus_mode && hb_dir == 8'hff) |=> hb_pin.oe_n == 8'hff)
        else $error("input direction did not release high-byte pins");
    a_latch_drives_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        (!bus_mode && hb_dir == 8'h00) |=> (hb_pin.oe_n == 8'h00 && hb_pin.out == $past(hb_latch)))
        else $error("output direction did not drive latch value");
    a_pin_read_level: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_read_take(gpio_def_pkg::idx_hb_pins) and in_bank1) |=> s_answer ##0 hrdata[7:0] == $past(hb_level))
        else $error("pin read did not return sampled level");
    a_ctl_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_take(gpio_def_pkg::idx_ctl_direction) |=> s_answer ##0 hrdata[31:4] == 28'h000_0000)
        else $error("control register upper bits not zero");
    a_bank_decode: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_read_take(gpio_def_pkg::idx_ctl_direction) and !in_bank1 and !in_bank5) |-> ##2 hrdata == 32'h0000_0000)
        else $error("control register answered outside bank 1");
    a_bus_strobes: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_mode |=> (ctl_pin.oe_n[2:0] == 3'b000 &&
            ctl_pin.out[2:0] == $past({sys_bus.wr_n, sys_bus.oe_n, sys_bus.ale})))
        else $error("bus strobes not on control pins");
    a_gpio_low_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        (!bus_mode && ctl_dir[2:0] == 3'b111) |=> ctl_pin.oe_n[2:0] == 3'b111)
        else $error("control pins driven outside bus mode");
    a_capture_pin_free: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_mode && ctl_dir[3]) |=> ctl_pin.oe_n[3])
        else $error("capture pin taken by bus");
    a_hb_bus_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_mode && sys_bus.ad_hi_drive && hb_dir == 8'hff) |=>
            (hb_pin.oe_n == 8'h00 && hb_pin.out == $past(sys_bus.ad_hi_out)))
        else $error("bus did not own high-byte pins");
    a_analog_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        warm_reset |-> ##2 (analog_select == 8'hff) [*2])
        else $error("analog-shared pins left analog mode after reset");
    a_warm_reset_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        warm_reset |=> (hb_dir == 8'hff && ctl_dir == 4'hf && hb_latch == $past(hb_latch)))
        else $error("warm reset handling of direction or latch wrong");
endmodule // shared_gpio_ports

// ===== bench/pin_world.sv
// far-side pad model for the high-byte, control and analog-shared ports
// assumes the drive structs of gpio_def_pkg and the bench clock
`timescale 1ns/1ps
module pin_world (
    input wire logic hclk,
    input wire gpio_def_pkg::port8_drive_t hb_pin,
    input wire gpio_def_pkg::port4_drive_t ctl_pin,
    input wire gpio_def_pkg::port8_drive_t as_pin,
    input wire logic [7:0] hb_ext,
    input wire logic [7:0] hb_en,
    input wire logic [3:0] ctl_ext,
    input wire logic [3:0] ctl_en,
    input wire logic [7:0] as_ext,
    input wire logic [7:0] as_en,
    output logic [7:0] hb_in,
    output logic [3:0] ctl_in,
    output logic [7:0] as_in
);
    // =========================================================
    // pad resolution
    // no pulls here: a pad nobody drives toggles every clock, so the agree stage never passes it and the last stable level keeps reading
    logic [7:0] drift = 8'h55;
    always @(posedge hclk)
        drift <= ~drift;
    // device drive wins a contention; the bench keeps ctl_en at 4'hf, so every control pin the device drives is contended
    assign hb_in = (~hb_pin.oe_n & hb_pin.out) | (hb_pin.oe_n & hb_en & hb_ext) | (hb_pin.oe_n & ~hb_en & drift);
    assign ctl_in = (~ctl_pin.oe_n & ctl_pin.out) | (ctl_pin.oe_n & ctl_en & ctl_ext)
        | (ctl_pin.oe_n & ~ctl_en & drift[3:0]);
    assign as_in = (~as_pin.oe_n & as_pin.out) | (as_pin.oe_n & as_en & as_ext) | (as_pin.oe_n & ~as_en & drift);
endmodule // pin_world

// ===== bench/shared_gpio_ports_tb.sv
// self-checking bench for the shared ports: AHB-Lite register access plus pad stimulus
// assumes pin_world on the pads and hready looped back from hreadyout
`timescale 1ns/1ps
module shared_gpio_ports_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic warm_reset = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cap_in;
    gpio_def_pkg::sys_bus_t sys_bus = '0;
    logic [7:0] ad_hi_in, hb_in, as_in, analog_select;
    logic [7:0] hb_ext = 8'h00, hb_en = 8'hff, as_ext = 8'h00, as_en = 8'hff;
    logic [3:0] ctl_in, ctl_ext = 4'h0, ctl_en = 4'hf;
    gpio_def_pkg::port8_drive_t hb_pin, as_pin;
    gpio_def_pkg::port4_drive_t ctl_pin;
    int fails = 0, total_checks = 0, cycles = 0;
    always #25 hclk = ~hclk;
    shared_gpio_ports shared_gpio_ports_i (.hclk(hclk), .hresetn(hresetn), .warm_reset(warm_reset),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_bus(sys_bus),
        .muxed_addr_data_hi_in(ad_hi_in), .capture_four_input(cap_in), .hb_pin_in(hb_in), .hb_pin(hb_pin),
        .ctl_pin_in(ctl_in), .ctl_pin(ctl_pin), .as_pin_in(as_in), .as_pin(as_pin),
        .analog_select(analog_select));
    pin_world pin_world_i (.hclk(hclk), .hb_pin(hb_pin), .ctl_pin(ctl_pin), .as_pin(as_pin), .hb_ext(hb_ext),
        .hb_en(hb_en), .ctl_ext(ctl_ext), .ctl_en(ctl_en), .as_ext(as_ext), .as_en(as_en), .hb_in(hb_in),
        .ctl_in(ctl_in), .as_in(as_in));
    // =========================================================
    // tasks
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // entered just after a rising edge; no wait count assumed, the timeout ends a hang
    task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {22'h00_0000, idx, 2'b00};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, idx, d, unused);
    endtask
    task rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] d;
        xfer(1'b0, idx, 32'h0000_0000, d);
        chk(d, exp, what);
        chk(hresp, 32'h0000_0000, "okay response");
    endtask
    // pads pass three flops and an agree stage before they show
    task settle;
        repeat (8) @(posedge hclk);
    endtask
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            $display("unexpected at %0t: run too long", $time);
            print_verdict;
        end
    end
    // =========================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(hb_pin.oe_n, 8'hff, "hb dir reset");
        chk(analog_select, 8'hff, "analog at reset");
        chk(as_pin.oe_n, 8'hff, "as undriven at reset");
        rd_chk(gpio_def_pkg::idx_hb_direction, 32'h0000_0000, "hb dir bank 0");
        wr(gpio_def_pkg::idx_bank_select, 32'h0000_0001);
        rd_chk(gpio_def_pkg::idx_hb_direction, 32'h0000_00ff, "hb dir read");
        rd_chk(gpio_def_pkg::idx_ctl_direction, 32'h0000_000f, "ctl dir read");
        wr(gpio_def_pkg::idx_hb_pins, 32'h0000_00a5);
        wr(gpio_def_pkg::idx_hb_direction, 32'h0000_000f);
        hb_ext <= 8'h03;
        hb_en <= 8'h0f;
        settle;
        chk(hb_pin.oe_n, 8'h0f, "hb drive");
        chk(hb_pin.out[7:4], 4'ha, "hb latch out");
        rd_chk(gpio_def_pkg::idx_hb_pins, 32'h0000_00a3, "hb pins read");
        wr(gpio_def_pkg::idx_ctl_pins, 32'hffff_fff5);
        wr(gpio_def_pkg::idx_ctl_direction, 32'hffff_fff0);
        settle;
        chk(ctl_pin.oe_n, 4'h0, "ctl gpio drive");
        chk(ctl_pin.out, 4'h5, "ctl out");
        rd_chk(gpio_def_pkg::idx_ctl_direction, 32'h0000_0000, "ctl dir high bits");
        rd_chk(gpio_def_pkg::idx_ctl_pins, 32'h0000_0005, "ctl pins read");
        wr(gpio_def_pkg::idx_bank_select, 32'h0000_0005);
        rd_chk(gpio_def_pkg::idx_ctl_direction, 32'h0000_0000, "ctl dir in bank 5");
        as_ext <= 8'h99;
        as_en <= 8'hf0;
        rd_chk(gpio_def_pkg::idx_as_pins, 32'h0000_0000, "as analog read");
        wr(gpio_def_pkg::idx_converter_cfg, 32'h0000_000e);
        wr(gpio_def_pkg::idx_as_pins, 32'h0000_003c);
        wr(gpio_def_pkg::idx_as_direction, 32'h0000_00f0);
        settle;
        chk(analog_select, 8'h00, "as digital");
        chk(as_pin.oe_n, 8'hf0, "as drive");
        rd_chk(gpio_def_pkg::idx_as_pins, 32'h0000_009c, "as pins read");
        wr(gpio_def_pkg::idx_bank_select, 32'h0000_0001);
        rd_chk(gpio_def_pkg::idx_as_pins, 32'h0000_0000, "as pins in bank 1");
        wr(gpio_def_pkg::idx_ctl_direction, 32'h0000_000f);
        wr(gpio_def_pkg::idx_hb_direction, 32'h0000_00ff);
        // fields: ale, oe_n, wr_n, ad_hi_drive, ad_hi_out
        sys_bus <= '{1'b1, 1'b0, 1'b1, 1'b1, 8'h5a};
        for (int m = 0; m < 4; m++)
        begin
            wr(gpio_def_pkg::idx_mode_config, 32'(m));
            settle;
            chk(ctl_pin.oe_n, m < 2 ? 4'h8 : 4'hf, "ctl owner by mode");
            chk(hb_pin.oe_n, m < 2 ? 8'h00 : 8'hff, "hb owner by mode");
        end
        wr(gpio_def_pkg::idx_mode_config, 32'h0000_0000);
        settle;
        chk(ctl_pin.out[2:0], 3'b101, "strobe levels");
        chk(hb_pin.out, 8'h5a, "upper bus byte out");
        sys_bus <= '{1'b0, 1'b1, 1'b0, 1'b0, 8'h5a};
        hb_ext <= 8'hc3;
        hb_en <= 8'hff;
        ctl_ext <= 4'h8;
        settle;
        chk(ctl_pin.out[2:0], 3'b010, "strobe polarity");
        chk(hb_pin.oe_n, 8'hff, "bus released");
        chk(ad_hi_in, 8'hc3, "upper bus byte in");
        chk(cap_in, 1'b1, "capture input");
        wr(gpio_def_pkg::idx_mode_config, 32'h0000_0002);
        warm_reset <= 1'b1;
        @(posedge hclk);
        warm_reset <= 1'b0;
        settle;
        chk(hb_pin.oe_n, 8'hff, "hb dir warm");
        chk(analog_select, 8'hff, "analog warm");
        rd_chk(gpio_def_pkg::idx_ctl_direction, 32'h0000_0000, "ctl dir in bank 0");
        wr(gpio_def_pkg::idx_bank_select, 32'h0000_0001);
        rd_chk(gpio_def_pkg::idx_ctl_direction, 32'h0000_000f, "ctl dir warm");
        wr(gpio_def_pkg::idx_hb_direction, 32'h0000_0000);
        settle;
        chk(hb_pin.out, 8'ha5, "hb latch kept");
        print_verdict;
    end
endmodule // shared_gpio_ports_tb
